// File: core/eeprom_access_defs.svh
// offsets, field positions, reset values and timing counts of the eeprom access controller
// assumes a 50 MHz system clock and an 8 MHz calibrated rc oscillator tick supplied by a divider
`ifndef EEPROM_ACCESS_DEFS_SVH
`define EEPROM_ACCESS_DEFS_SVH

// register indices on the i/o register port
`define REG_ADDR_HIGH 2'h0
`define REG_ADDR_LOW 2'h1
`define REG_DATA 2'h2
`define REG_CTRL 2'h3

// control register field positions
`define CTRL_READ_STROBE 0
`define CTRL_WRITE_STROBE 1
`define CTRL_MASTER_ARM 2
`define CTRL_READY_IRQ_EN 3
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5

// reset values
`define DATA_RESET 8'h00
`define MODE_RESET 2'h0

// array geometry
`define ADDR_BITS 10
`define ARRAY_DEPTH 1024

// timing: arm window and cpu stall counts in cpu cycles
`define ARM_WINDOW_CYCLES 3'h4
`define WRITE_STALL_CYCLES 3'h2
`define READ_STALL_CYCLES 3'h4

// calibrated rc oscillator: 8 MHz against a 50 MHz clock, tick every 6 clocks (rounded down)
`define SYS_CLK_HZ 50000000
`define RC_OSC_HZ 8000000
`define RC_DIV_CYCLES (`SYS_CLK_HZ / `RC_OSC_HZ)

// programming times in rc oscillator cycles, the half time scaled from the microsecond times
`define PROG_CYCLES_FULL 26368
`define PROG_TIME_FULL_US 3400
`define PROG_TIME_HALF_US 1800
`define PROG_CYCLES_HALF ((`PROG_CYCLES_FULL * `PROG_TIME_HALF_US) / `PROG_TIME_FULL_US)

`endif

// File: core/eeprom_access_pkg.sv
// types shared by the eeprom access controller files
// assumes nothing beyond the compile order: this package comes after the defs header
`default_nettype none

package eeprom_access_pkg;

  typedef enum logic [1:0] {
    mode_erase_write,
    mode_erase_only,
    mode_write_only,
    mode_reserved
  } prog_mode_t;

  typedef enum logic [1:0] {
    prog_idle,
    prog_busy
  } prog_state_t;

endpackage

`default_nettype wire

// File: core/rc_tick_divider.sv
// divider that turns the system clock into the rc oscillator tick enable
// assumes one system clock; the tick is a one-cycle pulse
`default_nettype none
`include "eeprom_access_defs.svh"

module rc_tick_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // tick out
  output logic tick
);

  localparam logic [3:0] DIV_LAST = 4'(`RC_DIV_CYCLES - 1);

  logic [3:0] count_r;
  wire logic wrap = (count_r == DIV_LAST);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      count_r <= 4'h0;
      tick <= 1'b0;
    end else begin
      count_r <= wrap ? 4'h0 : count_r + 4'h1;
      tick <= wrap;
    end
  end

endmodule

`default_nettype wire

// File: core/eeprom_array.sv
// byte storage standing in for the eeprom cells, held in flip-flops
// assumes erase leaves a byte at all ones and write-only ands the new data into the old
`default_nettype none
`include "eeprom_access_defs.svh"

module eeprom_array (
  // clock
  input wire logic sys_clk,
  // program port
  input wire logic prog_en,
  input wire logic [1:0] prog_mode,
  input wire logic [`ADDR_BITS-1:0] prog_addr,
  input wire logic [7:0] prog_data,
  // read port
  input wire logic [`ADDR_BITS-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] cells_r [`ARRAY_DEPTH];

  function automatic logic [7:0] program_byte(input logic [1:0] mode, input logic [7:0] old, input logic [7:0] nw);
    case (mode)
      2'h0: program_byte = nw;
      2'h1: program_byte = 8'hFF;
      2'h2: program_byte = old & nw;
      default: program_byte = old;
    endcase
  endfunction

  assign rd_data = cells_r[rd_addr];

  // cells have no reset on purpose: contents are nonvolatile
  always_ff @(posedge sys_clk) begin
    if (prog_en) begin
      cells_r[prog_addr] <= program_byte(prog_mode, cells_r[prog_addr], prog_data);
    end
  end

endmodule

`default_nettype wire

// File: core/eeprom_access_controller.sv
// register front end of the data eeprom: address, data and control registers, arm window,
// self-timed programming, ready interrupt request and cpu stall.
// assumes the cpu presents one-cycle i/o read and write strobes with a 2-bit register index
`default_nettype none
`include "eeprom_access_defs.svh"

// How it works
// - reserved address bits 15:10 and control bits 7:6 read as zero
// - the byte address is a linear index into locations 0 to 1023
// - data register feeds writes and receives the fetched byte on reads
// - mode field picks erase+write 3.4ms, erase 1.8ms, write 1.8ms, 11 reserved
// - mode field writes are ignored while the write strobe is set
// - reset clears the mode field unless programming is still running
// - ready request stands while write strobe clear, enables set, no self-programming
// - master write arm clears itself four cycles after software sets it
// - write strobe starts programming only while arm is set, else no effect
// - write strobe clears itself when the programming time has elapsed
// - an accepted write strobe stalls the cpu for two cycles
// - read strobe fetches the byte at once and stalls the cpu four cycles
// - during a write, reads are not performed and address changes are blocked
// - programming is timed by rc oscillator ticks, 26368 for a full write
// - a reset during programming lets that write complete
module eeprom_access_controller (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // cpu i/o register port
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [1:0] io_index,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // cpu status and control
  input wire logic global_irq_enable,
  input wire logic self_program_active,
  output logic cpu_stall,
  output logic ready_irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  logic [`ADDR_BITS-1:0] byte_address_reg_r;
  logic [7:0] data_byte_reg_r;
  eeprom_access_pkg::prog_mode_t program_mode_field_r;
  logic ready_irq_enable_r;
  logic master_write_arm_r;
  logic write_strobe_r;
  logic read_strobe_r;
  logic [2:0] arm_count_r;
  logic [2:0] stall_count_r;
  logic [14:0] prog_count_r;
  eeprom_access_pkg::prog_state_t prog_state_r;
  logic [1:0] prog_mode_r;
  logic [`ADDR_BITS-1:0] prog_addr_r;
  logic [7:0] prog_data_r;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  wire logic rc_tick;
  wire logic [7:0] array_rdata;
  wire logic busy = (prog_state_r == eeprom_access_pkg::prog_busy);
  wire logic wr_addr_high = io_write && (io_index == `REG_ADDR_HIGH);
  wire logic wr_addr_low = io_write && (io_index == `REG_ADDR_LOW);
  wire logic wr_data = io_write && (io_index == `REG_DATA);
  wire logic wr_ctrl = io_write && (io_index == `REG_CTRL);
  wire logic set_arm = wr_ctrl && io_wdata[`CTRL_MASTER_ARM];
  wire logic set_write = wr_ctrl && io_wdata[`CTRL_WRITE_STROBE];
  wire logic set_read = wr_ctrl && io_wdata[`CTRL_READ_STROBE];
  // a write strobe written in the same store that arms does nothing: arming must come first
  wire logic write_go = set_write && master_write_arm_r && !write_strobe_r && !busy && !reset;
  wire logic read_go = set_read && !write_strobe_r && !busy;
  wire logic addr_free = !busy && !write_strobe_r;
  wire logic prog_done = busy && rc_tick && (prog_count_r == 15'h0);
  wire logic [7:0] ctrl_view = {2'b00, program_mode_field_r, ready_irq_enable_r,
                                master_write_arm_r, write_strobe_r, read_strobe_r};

  function automatic logic [14:0] prog_length(input logic [1:0] mode);
    // length in rc ticks, minus one for the terminal tick
    case (mode)
      2'h0: prog_length = 15'(`PROG_CYCLES_FULL - 1);
      default: prog_length = 15'(`PROG_CYCLES_HALF - 1);
    endcase
  endfunction

  function automatic logic [7:0] read_view(input logic [1:0] idx, input logic [`ADDR_BITS-1:0] addr,
                                           input logic [7:0] data, input logic [7:0] ctrl);
    case (idx)
      2'h0: read_view = {6'h00, addr[9:8]};
      2'h1: read_view = addr[7:0];
      2'h2: read_view = data;
      default: read_view = ctrl;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // submodules

  rc_tick_divider u_rc_tick (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick(rc_tick)
  );

  eeprom_array u_array (
    .sys_clk(sys_clk),
    .prog_en(prog_done),
    .prog_mode(prog_mode_r),
    .prog_addr(prog_addr_r),
    .prog_data(prog_data_r),
    .rd_addr(byte_address_reg_r),
    .rd_data(array_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address and data registers
  // address has no reset value; software must load it before use

  always_ff @(posedge sys_clk) begin
    if (wr_addr_high && addr_free) begin
      byte_address_reg_r[9:8] <= io_wdata[1:0];
    end
    if (wr_addr_low && addr_free) begin
      byte_address_reg_r[7:0] <= io_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      data_byte_reg_r <= `DATA_RESET;
    end else if (read_go) begin
      data_byte_reg_r <= array_rdata;
    end else if (wr_data) begin
      data_byte_reg_r <= io_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      if (!busy) begin
        program_mode_field_r <= eeprom_access_pkg::prog_mode_t'(`MODE_RESET);
      end
      ready_irq_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      if (!write_strobe_r) begin
        program_mode_field_r <= eeprom_access_pkg::prog_mode_t'(io_wdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
      end
      ready_irq_enable_r <= io_wdata[`CTRL_READY_IRQ_EN];
    end
  end

  // arm window: counts down from three, arm drops when the window expires
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      master_write_arm_r <= 1'b0;
      arm_count_r <= 3'h0;
    end else if (set_arm) begin
      master_write_arm_r <= 1'b1;
      arm_count_r <= `ARM_WINDOW_CYCLES - 3'h1;
    end else if (master_write_arm_r) begin
      master_write_arm_r <= (arm_count_r != 3'h0);
      arm_count_r <= arm_count_r - 3'h1;
    end
  end

  // strobe mirrors programming; a reset never cuts a running write short
  always_ff @(posedge sys_clk) begin
    if (write_go) begin
      write_strobe_r <= 1'b1;
    end else if (prog_done || (reset && !busy)) begin
      write_strobe_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      read_strobe_r <= 1'b0;
    end else begin
      read_strobe_r <= read_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // self-timed programming; kept out of reset so an operation in flight finishes

  always_ff @(posedge sys_clk) begin
    case (prog_state_r)
      eeprom_access_pkg::prog_busy: begin
        if (prog_done) begin
          prog_state_r <= eeprom_access_pkg::prog_idle;
        end else if (rc_tick) begin
          prog_count_r <= prog_count_r - 15'h1;
        end
      end
      eeprom_access_pkg::prog_idle: begin
        if (write_go) begin
          prog_state_r <= eeprom_access_pkg::prog_busy;
          prog_count_r <= prog_length(program_mode_field_r);
          prog_mode_r <= program_mode_field_r;
          prog_addr_r <= byte_address_reg_r;
          prog_data_r <= data_byte_reg_r;
        end
      end
      default: begin
        prog_state_r <= eeprom_access_pkg::prog_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cpu stall, read data and ready request

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stall_count_r <= 3'h0;
    end else if (read_go) begin
      stall_count_r <= `READ_STALL_CYCLES;
    end else if (write_go) begin
      stall_count_r <= `WRITE_STALL_CYCLES;
    end else if (stall_count_r != 3'h0) begin
      stall_count_r <= stall_count_r - 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_stall <= 1'b0;
      io_rdata <= 8'h00;
      ready_irq <= 1'b0;
    end else begin
      cpu_stall <= read_go || write_go || (stall_count_r > 3'h1);
      io_rdata <= io_read ? read_view(io_index, byte_address_reg_r, data_byte_reg_r, ctrl_view) : 8'h00;
      ready_irq <= ready_irq_enable_r && global_irq_enable && !write_strobe_r && !self_program_active;
    end
  end

endmodule

`default_nettype wire

// File: verif/eeprom_access_props.sv
// assertions on the ports of the eeprom access controller
// assumes one clock, synchronous active-high reset, bound onto the controller
`default_nettype none
`include "eeprom_access_defs.svh"

module eeprom_access_props (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // cpu i/o register port
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [1:0] io_index,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  // cpu status and control
  input wire logic global_irq_enable,
  input wire logic self_program_active,
  input wire logic cpu_stall,
  input wire logic ready_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  // arm window as seen from the port; busy is only trusted through ready_irq
  logic [2:0] arm_age_r;
  wire ctrl_wr = io_write && io_index == `REG_CTRL;
  wire arm_wr = ctrl_wr && io_wdata[2] && !io_wdata[1];
  wire go_wr = ctrl_wr && io_wdata[1] && !io_wdata[0] && !cpu_stall;

  always_ff @(posedge sys_clk) begin
    if (reset) arm_age_r <= 3'h0;
    else if (arm_wr) arm_age_r <= 3'h4;
    else if (arm_age_r != 3'h0) arm_age_r <= arm_age_r - 3'h1;
  end

  sequence read_hold;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence
  sequence write_hold;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_read_stall_four: assert property (ctrl_wr && io_wdata[0] && !io_wdata[1] && ready_irq && !cpu_stall
    |=> read_hold) else $error("read stall is not four cycles");
  a_write_stall_two: assert property (go_wr && arm_age_r != 3'h0 && ready_irq
    |=> write_hold) else $error("write stall is not two cycles");
  a_strobe_needs_arm: assert property (go_wr && arm_age_r == 3'h0
    |=> !cpu_stall [*2]) else $error("write strobe accepted without arm");
  a_irq_off_write: assert property (go_wr && arm_age_r != 3'h0 && ready_irq
    |=> ##1 !ready_irq [*8]) else $error("ready request during write");
  a_irq_global_off: assert property (!global_irq_enable |=> !ready_irq)
    else $error("ready request with global enable clear");
  a_irq_spm_off: assert property (self_program_active |=> !ready_irq)
    else $error("ready request during self programming");
  a_ctrl_top_zero: assert property (io_read && io_index == `REG_CTRL |=> io_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_addr_top_zero: assert property (io_read && io_index == `REG_ADDR_HIGH |=> io_rdata[7:2] == 6'h00)
    else $error("address high top bits not zero");
  a_stall_max_four: assert property (cpu_stall [*4] |=> !cpu_stall)
    else $error("stall longer than four cycles");
endmodule

bind eeprom_access_controller eeprom_access_props i_eeprom_access_props (
  .sys_clk(sys_clk), .reset(reset), .io_write(io_write), .io_read(io_read), .io_index(io_index),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .global_irq_enable(global_irq_enable),
  .self_program_active(self_program_active), .cpu_stall(cpu_stall), .ready_irq(ready_irq)
);

`default_nettype wire

// File: verif/cpu_model.sv
// cpu side of the i/o register port: one-cycle write and read strobes
// assumes the bench calls wr and rd; no request is issued while cpu_stall is high
`default_nettype none

module cpu_model (
  // clock and status
  input wire logic sys_clk,
  input wire logic cpu_stall,
  input wire logic [7:0] io_rdata,
  // register port
  output logic io_write,
  output logic io_read,
  output logic [1:0] io_index,
  output logic [7:0] io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_write = 1'b0;
    io_read = 1'b0;
    io_index = 2'h0;
    io_wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stall is sampled at the falling edge so a stall launched by the last edge is seen
  task automatic wr(input logic [1:0] idx, input logic [7:0] dat);
    while (cpu_stall) @(negedge sys_clk);
    @(posedge sys_clk);
    io_write <= 1'b1;
    io_index <= idx;
    io_wdata <= dat;
    @(posedge sys_clk);
    io_write <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [1:0] idx, output logic [7:0] dat);
    while (cpu_stall) @(negedge sys_clk);
    @(posedge sys_clk);
    io_read <= 1'b1;
    io_index <= idx;
    @(posedge sys_clk);
    io_read <= 1'b0;
    @(negedge sys_clk);
    dat = io_rdata;
  endtask
endmodule

`default_nettype wire

// File: verif/testbench.sv
// self-checking bench of the eeprom access controller
// assumes the cpu model drives the register port; one erase-only write is timed in full
`default_nettype none
`include "eeprom_access_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic global_irq_enable = 1'b0;
  logic self_program_active = 1'b0;
  wire logic io_write, io_read, cpu_stall, ready_irq;
  wire logic [1:0] io_index;
  wire logic [7:0] io_wdata, io_rdata;
  logic [7:0] d;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int t0;
  int prog_clks;

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  eeprom_access_controller i_eeprom_access_controller (.sys_clk(sys_clk), .reset(reset),
    .io_write(io_write), .io_read(io_read), .io_index(io_index), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .self_program_active(self_program_active),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq));
  cpu_model i_cpu_model (.sys_clk(sys_clk), .cpu_stall(cpu_stall), .io_rdata(io_rdata),
    .io_write(io_write), .io_read(io_read), .io_index(io_index), .io_wdata(io_wdata));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [1:0] idx, input logic [7:0] exp);
    i_cpu_model.rd(idx, d);
    chk(d, exp);
  endtask

  // counts the stall cycles still ahead; called at the falling edge after the request is taken
  task automatic stall_chk(input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    while (cpu_stall === 1'b1 && n < 8'h09) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n, exp);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // a full run is about 85k cycles, dominated by one erase-only programming time
  initial begin
    repeat (95000) @(posedge sys_clk);
    err_total++;
    test_done;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    global_irq_enable <= 1'b1;
    i_cpu_model.wr(`REG_ADDR_HIGH, 8'hFF);
    rchk(`REG_ADDR_HIGH, 8'h03);
    i_cpu_model.wr(`REG_ADDR_LOW, 8'h5A);
    rchk(`REG_ADDR_LOW, 8'h5A);
    rchk(`REG_DATA, 8'h00);
    i_cpu_model.wr(`REG_DATA, 8'h3C);
    for (int m = 0; m < 4; m++) begin
      i_cpu_model.wr(`REG_CTRL, {2'h0, m[1:0], 4'h8});
      i_cpu_model.rd(`REG_CTRL, d);
      chk(d & 8'hFC, {2'h0, m[1:0], 4'h8});
    end
    $display("test registers done");
    i_cpu_model.wr(`REG_CTRL, 8'h18);
    i_cpu_model.wr(`REG_CTRL, 8'h1A);
    stall_chk(8'h00);
    rchk(`REG_CTRL, 8'h18);
    chk({7'h0, ready_irq}, 8'h01);
    @(posedge sys_clk) self_program_active <= 1'b1;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk({7'h0, ready_irq}, 8'h00);
    @(posedge sys_clk) self_program_active <= 1'b0;
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk) chk({7'h0, ready_irq}, 8'h00);
    @(posedge sys_clk) global_irq_enable <= 1'b1;
    // strobe one cycle after the window closes must be dropped
    i_cpu_model.wr(`REG_CTRL, 8'h1C);
    repeat (3) @(posedge sys_clk);
    i_cpu_model.wr(`REG_CTRL, 8'h1A);
    stall_chk(8'h00);
    rchk(`REG_CTRL, 8'h18);
    $display("test arm window done");
    i_cpu_model.wr(`REG_CTRL, 8'h1C);
    repeat (2) @(posedge sys_clk);
    i_cpu_model.wr(`REG_CTRL, 8'h1A);
    t0 = cyc;
    stall_chk(8'h02);
    rchk(`REG_CTRL, 8'h1A);
    chk({7'h0, ready_irq}, 8'h00);
    i_cpu_model.wr(`REG_ADDR_LOW, 8'h11);
    rchk(`REG_ADDR_LOW, 8'h5A);
    i_cpu_model.wr(`REG_CTRL, 8'h2E);
    i_cpu_model.rd(`REG_CTRL, d);
    chk(d & 8'hFB, 8'h1A);
    i_cpu_model.wr(`REG_CTRL, 8'h19);
    rchk(`REG_DATA, 8'h3C);
    @(posedge sys_clk) reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(`REG_CTRL, 8'h12);
    d = 8'h02;
    for (int k = 0; k < 45000 && d[1] !== 1'b0; k++) i_cpu_model.rd(`REG_CTRL, d);
    chk(d, 8'h10);
    // tick phase and poll spacing leave a few cycles of slack either way
    prog_clks = `PROG_CYCLES_HALF * `RC_DIV_CYCLES;
    chk({7'h0, (cyc - t0) >= prog_clks - 12 && (cyc - t0) <= prog_clks + 16}, 8'h01);
    $display("test erase write done");
    i_cpu_model.wr(`REG_CTRL, 8'h08);
    i_cpu_model.wr(`REG_CTRL, 8'h09);
    stall_chk(8'h04);
    rchk(`REG_DATA, 8'hFF);
    rchk(`REG_CTRL, 8'h08);
    $display("test read back done");
    // idle reset: mode field and data register go back to their reset values
    i_cpu_model.wr(`REG_CTRL, 8'h28);
    rchk(`REG_CTRL, 8'h28);
    @(posedge sys_clk) reset <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    rchk(`REG_CTRL, 8'h00);
    rchk(`REG_DATA, 8'h00);
    $display("test idle reset done");
    test_done;
  end
endmodule

`default_nettype wire
